// ==== inc/adcirq_regs.vh ====
// Purpose: Register map and field constants of the converter event block
// Assumes: Wishbone byte addresses, 32-bit words
// Notes:   Reset values of every register except CTRL live here
`ifndef ADCIRQ_REGS_VH
`define ADCIRQ_REGS_VH

`define ADCIRQ_ADDR_W         8
`define ADCIRQ_OFS_STATUS     8'h08
`define ADCIRQ_OFS_MASK       8'h0c
`define ADCIRQ_OFS_RAW        8'h10
`define ADCIRQ_OFS_RESULT     8'h14
`define ADCIRQ_OFS_OFFSET     8'h18
`define ADCIRQ_OFS_UPPER      8'h24
`define ADCIRQ_OFS_LOWER      8'h28
`define ADCIRQ_OFS_CTRL       8'h30

`define ADCIRQ_BIT_CAL        0
`define ADCIRQ_BIT_EOC        2
`define ADCIRQ_BIT_WIN        3
`define ADCIRQ_EVT_USED       4'hd

`define ADCIRQ_RST_MASK       4'hf
`define ADCIRQ_RST_ZERO4      4'h0
`define ADCIRQ_RST_ZERO16     16'h0000
`define ADCIRQ_RST_ZERO32     32'h00000000
`define ADCIRQ_RST_UPPER      32'hffffffff
`define ADCIRQ_RST_LOWER      32'h00000000

`define ADCIRQ_CTRL_BYPASS    0
`define ADCIRQ_CTRL_WINEN     1

`endif

// ==== core/adcirq_win.v ====
// Purpose: Window comparator for one signed conversion sample
// Assumes: Sample and limits are two's complement
// Notes:   Limits inclusive
`timescale 1ns/1ps
module adcirq_win (
	input  wire        [15:0] sample_i,
	input  wire        [31:0] upper_limit_i,
	input  wire        [31:0] lower_limit_i,
	output wire               inside_o
);
	wire signed [31:0] ext_w;
	assign ext_w    = {{16{sample_i[15]}}, sample_i};
	assign inside_o = (ext_w <= $signed(upper_limit_i)) && (ext_w >= $signed(lower_limit_i));
endmodule

// ==== core/adcirq_top.v ====
// Purpose: Event, mask, result and offset registers of the converter
// Assumes: Classic Wishbone slave, ack one cycle after request
// Notes:   Set wins over clear-on-read
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "adcirq_regs.vh"
module adcirq_top (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [31:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output wire        wb_err_o,
	input  wire        cal_done_i,
	input  wire        conv_done_i,
	input  wire [15:0] conv_data_i,
	output wire [15:0] offset_o,
	output wire        bypass_o,
	output wire        irq_o
);

////////////////////////////////////////////////////////////////////////////////
// Registers

	reg  [3:0]  raw_r;
	reg  [3:0]  raw_nxt;
	reg  [3:0]  mask_r;
	reg  [31:0] result_r;
	reg  [31:0] offset_r;
	reg  [31:0] upper_r;
	reg  [31:0] lower_r;
	reg  [1:0]  ctrl_r;
	reg  [31:0] rdata_nxt;
	reg         hit_r;
	wire        inside_w;
	wire        req_w;
	wire        wr_w;
	wire        rd_w;
	wire [7:0]  ofs_w;
	wire [3:0]  masked_w;
	wire        rd_stat_w;
	wire        rd_raw_w;

	assign req_w    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_w     = req_w && wb_we_i;
	assign rd_w     = req_w && !wb_we_i;
	assign ofs_w    = wb_adr_i[`ADCIRQ_ADDR_W-1:0];
	assign wb_err_o = 1'b0;
	assign rd_stat_w = rd_w && (ofs_w == `ADCIRQ_OFS_STATUS);
	assign rd_raw_w  = rd_w && (ofs_w == `ADCIRQ_OFS_RAW);

	function [31:0] adcirq_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  sel_v;
		begin
			adcirq_merge = {sel_v[3] ? new_v[31:24] : old_v[31:24],
			                sel_v[2] ? new_v[23:16] : old_v[23:16],
			                sel_v[1] ? new_v[15:8]  : old_v[15:8],
			                sel_v[0] ? new_v[7:0]   : old_v[7:0]};
		end
	endfunction

	adcirq_win u_win (
		.sample_i      (conv_data_i),
		.upper_limit_i (upper_r),
		.lower_limit_i (lower_r),
		.inside_o      (inside_w)
	);

////////////////////////////////////////////////////////////////////////////////
// Events

	always @* begin
		raw_nxt = raw_r;
		if (rd_stat_w || rd_raw_w) begin
			raw_nxt = `ADCIRQ_RST_ZERO4;
		end
		if (cal_done_i) begin
			raw_nxt[`ADCIRQ_BIT_CAL] = 1'b1;
		end
		if (conv_done_i) begin
			raw_nxt[`ADCIRQ_BIT_EOC] = 1'b1;
			if (ctrl_r[`ADCIRQ_CTRL_WINEN] && inside_w) begin
				raw_nxt[`ADCIRQ_BIT_WIN] = 1'b1;
			end
		end
		raw_nxt = raw_nxt & `ADCIRQ_EVT_USED;
	end

	assign masked_w = raw_r & ~mask_r & `ADCIRQ_EVT_USED;
	assign irq_o    = |masked_w;

	always @(posedge clk_i) begin
		if (rst_i) begin
			raw_r    <= `ADCIRQ_RST_ZERO4;
			result_r <= `ADCIRQ_RST_ZERO32;
			hit_r    <= 1'b0;
		end else begin
			raw_r <= raw_nxt;
			if (conv_done_i) begin
				hit_r <= inside_w;
				if (ctrl_r[`ADCIRQ_CTRL_BYPASS]) begin
					result_r <= {`ADCIRQ_RST_ZERO16, conv_data_i};
				end else begin
					result_r <= {conv_data_i, `ADCIRQ_RST_ZERO16};
				end
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Offset selection

	assign bypass_o = ctrl_r[`ADCIRQ_CTRL_BYPASS];
	assign offset_o = bypass_o ? offset_r[15:0]
	                           : offset_r[31:16];

////////////////////////////////////////////////////////////////////////////////
// Bus writes

	always @(posedge clk_i) begin
		if (rst_i) begin
			mask_r   <= `ADCIRQ_RST_MASK;
			offset_r <= `ADCIRQ_RST_ZERO32;
			upper_r  <= `ADCIRQ_RST_UPPER;
			lower_r  <= `ADCIRQ_RST_LOWER;
			ctrl_r   <= 2'b00;
		end else if (wr_w) begin
			if (ofs_w == `ADCIRQ_OFS_MASK) begin
				if (wb_sel_i[0]) begin
					mask_r <= wb_dat_i[3:0];
				end
			end else if (ofs_w == `ADCIRQ_OFS_OFFSET) begin
				offset_r <= adcirq_merge(offset_r, wb_dat_i, wb_sel_i);
			end else if (ofs_w == `ADCIRQ_OFS_UPPER) begin
				upper_r <= adcirq_merge(upper_r, wb_dat_i, wb_sel_i);
			end else if (ofs_w == `ADCIRQ_OFS_LOWER) begin
				lower_r <= adcirq_merge(lower_r, wb_dat_i, wb_sel_i);
			end else if (ofs_w == `ADCIRQ_OFS_CTRL) begin
				if (wb_sel_i[0]) begin
					ctrl_r <= wb_dat_i[1:0];
				end
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Bus reads

	always @* begin
		rdata_nxt = `ADCIRQ_RST_ZERO32;
		if (ofs_w == `ADCIRQ_OFS_STATUS) begin
			rdata_nxt = {28'h0000000, masked_w};
		end else if (ofs_w == `ADCIRQ_OFS_MASK) begin
			rdata_nxt = {28'h0000000, mask_r};
		end else if (ofs_w == `ADCIRQ_OFS_RAW) begin
			rdata_nxt = {28'h0000000, raw_r};
		end else if (ofs_w == `ADCIRQ_OFS_RESULT) begin
			rdata_nxt = result_r;
		end else if (ofs_w == `ADCIRQ_OFS_OFFSET) begin
			rdata_nxt = offset_r;
		end else if (ofs_w == `ADCIRQ_OFS_UPPER) begin
			rdata_nxt = upper_r;
		end else if (ofs_w == `ADCIRQ_OFS_LOWER) begin
			rdata_nxt = lower_r;
		end else if (ofs_w == `ADCIRQ_OFS_CTRL) begin
			rdata_nxt = {29'h00000000, hit_r, ctrl_r};
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `ADCIRQ_RST_ZERO32;
		end else begin
			wb_ack_o <= req_w;
			if (rd_w) begin
				wb_dat_o <= rdata_nxt;
			end
		end
	end

endmodule

// ==== verif/adcirq_chk_properties.sv ====
// Purpose: Bus and event checks on the ports of adcirq_top
// Assumes: One clock, ack one cycle after a request
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module adcirq_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic        cal_done_i,
	input wire logic        conv_done_i,
	input wire logic [15:0] offset_o,
	input wire logic        bypass_o,
	input wire logic        irq_o
);
////////////////////////////////////////
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
sequence rd(a);
	wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i[7:0] == a;
endsequence
sequence calm_ack;
	wb_ack_o && !cal_done_i && !conv_done_i;
endsequence
a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
a_err_low: assert property (!wb_err_o) else $error("err raised");
a_reset_vals: assert property ($fell(rst_i) |-> !irq_o && offset_o == 16'h0 && !bypass_o)
	else $error("bad reset outputs");
a_stat_rsvd: assert property (rd(8'h08) |=> wb_dat_o[31:4] == 28'h0 && !wb_dat_o[1])
	else $error("status reserved set");
a_raw_rsvd: assert property (rd(8'h10) |=> wb_dat_o[31:4] == 28'h0 && !wb_dat_o[1])
	else $error("raw reserved set");
a_hole_zero: assert property (rd(8'h40) |=> wb_dat_o == 32'h0) else $error("hole not zero");
a_read_clr: assert property (rd(8'h08) ##1 calm_ack |=> !irq_o)
	else $error("irq after clear");
a_dat_hold: assert property (!(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o)) else $error("read data moved");
endmodule

// ==== verif/adcirq_top_tb.sv ====
// Purpose: Self-checking bench of adcirq_top
// Assumes: Control register at 0x30 as the design chose
// Notes:   Classic Wishbone master tasks
`timescale 1ns/1ps
module adcirq_top_tb;
logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, cal = 0, conv = 0;
logic [31:0] adr = 0, dat = 0, rdat, wb_dat_o;
logic [15:0] cdat = 0, offset_o;
logic        wb_ack_o, bypass_o, irq_o;
int          err_count = 0, checked = 0, cycles = 0;
adcirq_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
	.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(), .cal_done_i(cal),
	.conv_done_i(conv), .conv_data_i(cdat), .offset_o(offset_o), .bypass_o(bypass_o), .irq_o(irq_o));
////////////////////////////////////////
initial forever #5 clk_i = ~clk_i;
always @(posedge clk_i) begin
	cycles <= cycles + 1;
	if (cycles == 3000) begin
		err_count++;
		finish_test();
	end
end
task finish_test();
	$display("checks %0d errors %0d", checked, err_count);
	if (err_count == 0 && checked > 0) $display("Result: passed");
	else $display("Result: failed");
	$finish;
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
	checked++;
	if (g !== e) begin
		err_count++;
		$display("[FAIL] %0t got %h exp %h", $time, g, e);
	end
endtask
task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
	@(posedge clk_i);
	cyc <= 1; stb <= 1; we <= w; adr <= {24'h0, a}; dat <= d;
	do @(posedge clk_i); while (wb_ack_o !== 1'b1);
	rdat = wb_dat_o;
	cyc <= 0; stb <= 0; we <= 0;
endtask
task rd(input logic [7:0] a, input logic [31:0] e);
	wb(0, a, 0);
	chk(rdat, e);
endtask
task ev(input logic c, input logic v, input logic [15:0] d);
	@(posedge clk_i);
	cal <= c; conv <= v; cdat <= d;
	@(posedge clk_i);
	cal <= 0; conv <= 0;
endtask
task irq(input logic e);
	@(negedge clk_i);
	chk({31'h0, irq_o}, {31'h0, e});
endtask
task t_reset();
	rd(8'h0c, 32'hf);
	rd(8'h08, 0); rd(8'h10, 0); rd(8'h14, 0); rd(8'h18, 0); rd(8'h28, 0);
	irq(0);
endtask
task t_cal();
	ev(1, 0, 0); irq(0);
	rd(8'h10, 32'h1); rd(8'h10, 0);
	wb(1, 8'h0c, 32'he); ev(1, 0, 0); irq(1);
	rd(8'h08, 32'h1); irq(0); rd(8'h08, 0);
endtask
task t_win();
	wb(1, 8'h30, 32'h2); wb(1, 8'h24, 32'd100); wb(1, 8'h28, 32'hfffffffb); wb(1, 8'h0c, 0);
	ev(0, 1, 16'd50); irq(1); rd(8'h08, 32'hc);
	ev(0, 1, 16'd200); rd(8'h10, 32'h4); rd(8'h14, 32'h00c80000);
	wb(1, 8'h0c, 32'hb); ev(0, 1, 16'd200); irq(1);
	wb(1, 8'h0c, 32'h7); irq(0); rd(8'h10, 32'h4);
endtask
task t_bypass();
	wb(1, 8'h30, 32'h1); ev(0, 1, 16'h8123); rd(8'h10, 32'h4); chk(bypass_o, 1);
	wb(1, 8'h14, 0); rd(8'h14, 32'h00008123);
	wb(1, 8'h18, 32'h1234abcd); irq(0); chk(offset_o, 16'habcd);
	wb(1, 8'h30, 0); irq(0); chk(offset_o, 16'h1234); rd(8'h18, 32'h1234abcd);
	rd(8'h24, 32'd100); rd(8'h40, 0);
endtask
initial begin
	repeat (16) @(posedge clk_i);
	rst_i <= 0;
	t_reset(); t_cal(); t_win(); t_bypass();
	finish_test();
end
endmodule
bind adcirq_top adcirq_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.cal_done_i(cal_done_i), .conv_done_i(conv_done_i), .offset_o(offset_o), .bypass_o(bypass_o), .irq_o(irq_o));
